// *** logic/fpes_pkg.sv ***
// How it works
// [RULE_01] byte program is two unlock writes, setup command, then address with data
// [RULE_02] device programs and verifies alone, then returns to array read
// [RULE_03] device reports progress by data-poll, toggle and ready/busy signals
// [RULE_04] device ignores command writes while its internal algorithm runs
// [RULE_05] hardware reset ends programming; host repeats sequence afterwards
// [RULE_06] program never turns a 0 into 1; timeout-error bit may rise
// [RULE_07] write buffer holds at most 32 bytes per operation
// [RULE_08] host writes unlocks, buffer-load at sector, then location count minus one
// [RULE_09] device aborts when the location count exceeds the buffer size
// [RULE_10] all pairs sit in one buffer page chosen by address bits 5 upward
// [RULE_11] load counter drops on every load; last data for a location wins
// [RULE_12] after the last load host writes confirm at sector, then polls last address
// [RULE_13] buffer abort shows abort bit 1, inverted data-poll, toggling, no timeout
// [RULE_14] after a buffer abort host writes the three-cycle abort reset
// [RULE_15] program suspend needs no address; device halts within 15 us
// [RULE_16] suspend also accepted while programming inside an erase suspend
// [RULE_17] identifier reads allowed while suspended; exit returns to suspended state
// [RULE_18] program resume restarts programming; poll as in normal programming
// [RULE_19] erase is six writes: unlocks, 80, unlocks, then 10 chip or 30 sector
// [RULE_20] erase pre-programs the whole array to zeros on its own
// [RULE_21] during chip erase commands ignored, reset stops it, status reported
// [RULE_22] identifier read: address 0 gives maker code, address 1 device code
// [RULE_23] a buffered sequence runs at most 37 cycles
// [RULE_24] sector is selected by address bits 22 down to 12
package fpes_pkg;

  localparam int CLK_NS       = 100;
  localparam int WE_NS        = 200;
  localparam int GAP_NS       = 200;
  localparam int ACC_NS       = 300;
  localparam int SUSPEND_NS   = 15000;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_RECOV_NS = 1000;
  localparam int WE_CYC       = (WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC      = (GAP_NS + CLK_NS - 1) / CLK_NS;
  // two extra cycles for the data synchroniser
  localparam int RD_CYC       = (ACC_NS + CLK_NS - 1) / CLK_NS + 2;
  localparam int SUSPEND_CYC  = (SUSPEND_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_CYC      = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC    = (RST_RECOV_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_LOAD = 8'h0C;
  localparam logic [7:0] REG_ID   = 8'h10;
  localparam logic [7:0] REG_POLL = 8'h14;

  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_ABORT = 2;
  localparam int ST_ERROR = 3;
  localparam int ST_SUSP  = 4;
  localparam int ST_RYBY  = 5;
  localparam int LOAD_OFF = 8;

  localparam logic [22:0] UNLOCK_ADDR = 23'h00_0000;
  localparam logic [7:0] CMD_UNLOCK1  = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2  = 8'h55;
  localparam logic [7:0] CMD_PROG     = 8'hA0;
  localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUF_CONF = 8'h29;
  localparam logic [7:0] CMD_RESET    = 8'hF0;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_CHIP     = 8'h10;
  localparam logic [7:0] CMD_SECTOR   = 8'h30;
  localparam logic [7:0] CMD_SUSPEND  = 8'hB0;
  localparam logic [7:0] CMD_RESUME   = 8'h30;
  localparam logic [7:0] CMD_ID       = 8'h90;
  localparam logic [7:0] ERASED       = 8'hFF;

  localparam logic [1:0] K_END = 2'h0;
  localparam logic [1:0] K_WR  = 2'h1;
  localparam logic [1:0] K_RD  = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_BYTE = 4'h1, OP_BUFFER = 4'h2, OP_CHIP = 4'h3,
    OP_SECTOR = 4'h4, OP_SUSPEND = 4'h5, OP_RESUME = 4'h6, OP_ID = 4'h7,
    OP_ABORT_RST = 4'h8, OP_HWRESET = 4'h9
  } fpes_op_e;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_STEP = 7'h02, S_WR = 7'h04, S_GAP = 7'h08,
    S_RD = 7'h10, S_WAIT = 7'h20, S_RST = 7'h40
  } fpes_state_e;

  typedef struct packed {
    logic [1:0]  kind;
    logic [22:0] a;
    logic [7:0]  d;
  } fpes_step_s;

  typedef struct packed {
    logic [22:0] a;
    logic [7:0]  dq;
    logic        dq_oe_n;
    logic        we_n;
    logic        oe_n;
    logic        ce_n;
    logic        reset_n;
  } fpes_pins_s;

endpackage

// *** logic/fpes_host.sv ***
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fpes_host
  import fpes_pkg::*;
#(
  parameter int BUF_DEPTH = 32
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        EN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic      [22:0] F_A,
  input  wire logic [7:0]  F_DQ_I,
  output logic      [7:0]  F_DQ_O,
  output logic             F_DQ_OE_N,
  output logic             F_WE_N,
  output logic             F_OE_N,
  output logic             F_CE_N,
  output logic             F_RESET_N,
  input  wire logic        F_READY_BUSY_N
);

  if (BUF_DEPTH < 1 || BUF_DEPTH > 32) begin : g_chk
    $error("BUF_DEPTH must be 1 to 32"); // [RULE_07]
  end

  typedef struct packed {
    fpes_state_e                  state;
    fpes_op_e                     op;
    logic [5:0]                   idx;
    logic [7:0]                   timer;
    logic [22:0]                  addr;
    logic [7:0]                   data;
    logic [BUF_DEPTH-1:0][12:0]   ram;
    logic [5:0]                   cnt;
    logic [22:0]                  poll_a;
    logic [7:0]                   poll_d;
    logic                         polling;
    logic                         poll_buf;
    logic                         q5_seen;
    logic                         done;
    logic                         aborted;
    logic                         failed;
    logic                         suspended;
    logic [7:0]                   id_mfr;
    logic [7:0]                   id_dev;
    logic [7:0]                   last_q;
    fpes_pins_s                   pins;
    logic [31:0]                  rdata;
    logic [7:0]                   dq_s1;
    logic [7:0]                   dq_s2;
    logic                         ry_s1;
    logic                         ry_s2;
  } fpes_regs_s;

  function automatic fpes_regs_s init_regs();
    fpes_regs_s r;
    r              = '0;
    r.state        = S_IDLE;
    r.op           = OP_NONE;
    r.pins.dq_oe_n = 1'b1;
    r.pins.we_n    = 1'b1;
    r.pins.oe_n    = 1'b1;
    r.pins.ce_n    = 1'b1;
    r.pins.reset_n = 1'b1;
    return r;
  endfunction

  localparam fpes_regs_s RST_VAL = init_regs();

  function automatic fpes_step_s mk(logic [1:0] k, logic [22:0] a, logic [7:0] d);
    fpes_step_s s;
    s.kind = k;
    s.a    = a;
    s.d    = d;
    return s;
  endfunction

  function automatic fpes_step_s step_of(fpes_op_e op, logic [5:0] i, logic [22:0] a,
                                         logic [7:0] d, logic [5:0] n, logic [12:0] e);
    fpes_step_s s;
    s = mk(K_END, UNLOCK_ADDR, 8'h00);
    if (op inside {OP_BYTE, OP_BUFFER, OP_CHIP, OP_SECTOR, OP_ABORT_RST, OP_ID}
        && i < 6'd2) begin
      s = mk(K_WR, UNLOCK_ADDR, (i == 6'd0) ? CMD_UNLOCK1 : CMD_UNLOCK2);
    end else begin
      case (op)
        OP_BYTE: begin
          if (i == 6'd2) s = mk(K_WR, UNLOCK_ADDR, CMD_PROG); // [RULE_01]
          if (i == 6'd3) s = mk(K_WR, a, d);                  // [RULE_01]
        end
        OP_BUFFER: begin
          // a holds a sector address, bits 22..12 [RULE_24]
          if (i == 6'd2) s = mk(K_WR, a, CMD_BUF_LOAD);               // [RULE_08]
          else if (i == 6'd3) s = mk(K_WR, a, 8'(n - 6'd1));          // [RULE_08]
          else if (i < n + 6'd4) s = mk(K_WR, {a[22:5], e[12:8]}, e[7:0]); // [RULE_10]
          else if (i == n + 6'd4) s = mk(K_WR, a, CMD_BUF_CONF);      // [RULE_12]
        end
        OP_CHIP, OP_SECTOR: begin
          if (i == 6'd2) s = mk(K_WR, UNLOCK_ADDR, CMD_ERASE);        // [RULE_19]
          if (i == 6'd3) s = mk(K_WR, UNLOCK_ADDR, CMD_UNLOCK1);
          if (i == 6'd4) s = mk(K_WR, UNLOCK_ADDR, CMD_UNLOCK2);
          if (i == 6'd5) s = (op == OP_CHIP) ? mk(K_WR, UNLOCK_ADDR, CMD_CHIP)
                                             : mk(K_WR, a, CMD_SECTOR); // [RULE_19]
        end
        OP_SUSPEND: if (i == 6'd0) s = mk(K_WR, UNLOCK_ADDR, CMD_SUSPEND); // [RULE_15]
        OP_RESUME:  if (i == 6'd0) s = mk(K_WR, UNLOCK_ADDR, CMD_RESUME);  // [RULE_18]
        OP_ABORT_RST: if (i == 6'd2) s = mk(K_WR, UNLOCK_ADDR, CMD_RESET); // [RULE_14]
        OP_ID: begin
          if (i == 6'd2) s = mk(K_WR, UNLOCK_ADDR, CMD_ID);
          if (i == 6'd3) s = mk(K_RD, 23'h00_0000, 8'h00); // [RULE_22]
          if (i == 6'd4) s = mk(K_RD, 23'h00_0001, 8'h00); // [RULE_22]
          // leaving id mode; a suspended program stays suspended [RULE_17]
          if (i == 6'd5) s = mk(K_WR, UNLOCK_ADDR, CMD_RESET);
        end
        default: s = mk(K_END, UNLOCK_ADDR, 8'h00);
      endcase
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  fpes_regs_s st;
  fpes_regs_s next_st;
  fpes_step_s step;
  fpes_op_e   wop;
  logic [7:0] q;
  logic       accept;

  always_comb begin
    step = step_of(st.op, st.idx, st.addr, st.data, st.cnt, st.ram[5'(st.idx - 6'd4)]);
    wop  = fpes_op_e'(WDATA[3:0]);
    q    = st.dq_s2;
    // only suspend or reset may cut into a running algorithm [RULE_04] [RULE_16]
    accept = WR && (ADDR == REG_CTRL) && (wop != OP_NONE) &&
             ((st.state == S_IDLE) ||
              (st.polling && (wop == OP_SUSPEND || wop == OP_HWRESET) &&
               // a poll that ends this cycle keeps its result; the set wins
               !(st.state == S_RD && st.timer == 8'd0)));
    next_st       = st;
    next_st.dq_s1 = F_DQ_I;
    next_st.dq_s2 = st.dq_s1;
    next_st.ry_s1 = F_READY_BUSY_N;
    next_st.ry_s2 = st.ry_s1;
    next_st.rdata = 32'h0000_0000;
    if (RD) begin
      case (ADDR)
        REG_CTRL: begin
          next_st.rdata[ST_BUSY]  = (st.state != S_IDLE);
          next_st.rdata[ST_DONE]  = st.done;
          next_st.rdata[ST_ABORT] = st.aborted;
          next_st.rdata[ST_ERROR] = st.failed;
          next_st.rdata[ST_SUSP]  = st.suspended;
          next_st.rdata[ST_RYBY]  = st.ry_s2; // [RULE_03]
        end
        REG_ADDR: next_st.rdata = {9'h000, st.addr};
        REG_DATA: next_st.rdata = {24'h00_0000, st.data};
        REG_LOAD: next_st.rdata = {26'h000_0000, st.cnt};
        REG_ID:   next_st.rdata = {16'h0000, st.id_dev, st.id_mfr};
        REG_POLL: next_st.rdata = {24'h00_0000, st.last_q};
        default:  next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (WR && st.state == S_IDLE) begin
      if (ADDR == REG_ADDR) next_st.addr = WDATA[22:0];
      if (ADDR == REG_DATA) next_st.data = WDATA[7:0];
      // every load takes a slot, repeats included; extra loads are dropped
      if (ADDR == REG_LOAD && st.cnt < 6'(BUF_DEPTH)) begin // [RULE_11] [RULE_09]
        next_st.ram[5'(st.cnt)] = WDATA[LOAD_OFF+4:0];
        next_st.cnt             = st.cnt + 6'd1;
      end
    end

    case (st.state)
      S_IDLE: next_st.state = S_IDLE;
      S_STEP: begin
        if (st.polling) begin
          next_st.pins.a    = st.poll_a; // [RULE_12]
          next_st.pins.oe_n = 1'b0;
          next_st.timer     = 8'(RD_CYC - 1);
          next_st.state     = S_RD;
        end else if (step.kind == K_WR) begin
          next_st.pins.a       = step.a;
          next_st.pins.dq      = step.d;
          next_st.pins.dq_oe_n = 1'b0;
          next_st.pins.we_n    = 1'b0; // [RULE_01]
          next_st.timer        = 8'(WE_CYC - 1);
          next_st.state        = S_WR;
          if (st.op == OP_BUFFER && st.idx >= 6'd4 && st.idx < st.cnt + 6'd4) begin
            next_st.poll_a = step.a; // [RULE_12]
            next_st.poll_d = step.d;
          end
        end else if (step.kind == K_RD) begin
          next_st.pins.a    = step.a;
          next_st.pins.oe_n = 1'b0;
          next_st.timer     = 8'(RD_CYC - 1);
          next_st.state     = S_RD;
        end else begin
          case (st.op)
            OP_BYTE, OP_BUFFER, OP_CHIP, OP_SECTOR, OP_RESUME: begin
              next_st.polling   = 1'b1; // [RULE_18] [RULE_20] [RULE_21]
              next_st.suspended = 1'b0;
            end
            OP_SUSPEND: begin
              next_st.timer = 8'(SUSPEND_CYC - 1); // [RULE_15]
              next_st.state = S_WAIT;
            end
            default: begin
              next_st.done  = 1'b1;
              next_st.state = S_IDLE;
            end
          endcase
        end
      end
      S_WR: begin
        next_st.timer = st.timer - 8'd1;
        if (st.timer == 8'd0) begin
          next_st.pins.we_n = 1'b1;
          next_st.timer     = 8'(GAP_CYC - 1);
          next_st.state     = S_GAP;
        end
      end
      S_GAP: begin
        next_st.timer = st.timer - 8'd1;
        if (st.timer == 8'd0) begin
          next_st.pins.dq_oe_n = 1'b1;
          next_st.state        = S_STEP;
          if (!st.polling) next_st.idx = st.idx + 6'd1;
        end
      end
      S_RD: begin
        next_st.timer = st.timer - 8'd1;
        if (st.timer == 8'd0) begin
          next_st.pins.oe_n = 1'b1;
          next_st.last_q    = q;
          next_st.timer     = 8'(GAP_CYC - 1);
          next_st.state     = S_GAP;
          if (!st.polling) begin
            if (st.idx == 6'd3) next_st.id_mfr = q; // [RULE_22]
            if (st.idx == 6'd4) next_st.id_dev = q;
          end else begin
            if (q[7] == st.poll_d[7]) begin
              next_st.done = 1'b1; // back in array read [RULE_02]
            end else if (st.poll_buf && q[1]) begin
              next_st.aborted = 1'b1; // [RULE_13]
            end else if (q[5] && st.q5_seen) begin
              next_st.failed = 1'b1; // [RULE_06]
            end else begin
              next_st.q5_seen = st.q5_seen | q[5];
            end
            if (next_st.done || next_st.aborted || next_st.failed) begin
              next_st.polling = 1'b0;
              next_st.state   = S_IDLE;
              if (st.poll_buf) next_st.cnt = 6'd0;
            end
          end
        end
      end
      S_WAIT: begin
        next_st.timer = st.timer - 8'd1;
        if (st.timer == 8'd0) begin
          next_st.done      = 1'b1;
          next_st.suspended = 1'b1; // [RULE_15]
          next_st.state     = S_IDLE;
        end
      end
      S_RST: begin
        next_st.timer = st.timer - 8'd1;
        if (st.timer == 8'd0) begin
          if (!st.pins.reset_n) begin
            next_st.pins.reset_n = 1'b1;
            next_st.timer        = 8'(RECOV_CYC - 1);
          end else begin
            next_st.done  = 1'b1; // caller repeats the interrupted sequence [RULE_05]
            next_st.state = S_IDLE;
          end
        end
      end
      default: next_st = RST_VAL;
    endcase

    if (accept) begin
      next_st.op        = wop;
      next_st.idx       = 6'd0;
      next_st.polling   = 1'b0;
      next_st.q5_seen   = 1'b0;
      next_st.done      = 1'b0;
      next_st.aborted   = 1'b0;
      next_st.failed    = 1'b0;
      next_st.pins.oe_n = 1'b1;
      next_st.state     = S_STEP;
      next_st.poll_buf  = (wop == OP_BUFFER);
      if (wop == OP_BYTE) begin
        next_st.poll_a = st.addr;
        next_st.poll_d = st.data;
      end
      if (wop == OP_CHIP || wop == OP_SECTOR) begin
        next_st.poll_a = st.addr;
        next_st.poll_d = ERASED;
      end
      if (wop == OP_BUFFER && st.cnt == 6'd0) begin
        next_st.failed = 1'b1;
        next_st.state  = S_IDLE;
      end
      if (wop == OP_HWRESET) begin
        next_st.pins.reset_n = 1'b0; // [RULE_05]
        next_st.pins.we_n    = 1'b1;
        next_st.pins.dq_oe_n = 1'b1;
        next_st.suspended    = 1'b0;
        next_st.cnt          = 6'd0;
        next_st.timer        = 8'(RST_CYC - 1);
        next_st.state        = S_RST;
      end
    end
    next_st.pins.ce_n = (next_st.state == S_IDLE) || (next_st.state == S_RST);
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= RST_VAL;
    end else if (EN) begin
      st <= next_st;
    end
  end

  assign RDATA     = st.rdata;
  assign F_A       = st.pins.a;
  assign F_DQ_O    = st.pins.dq;
  assign F_DQ_OE_N = st.pins.dq_oe_n;
  assign F_WE_N    = st.pins.we_n;
  assign F_OE_N    = st.pins.oe_n;
  assign F_CE_N    = st.pins.ce_n;
  assign F_RESET_N = st.pins.reset_n;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  logic wr_buf;
  assign wr_buf = (st.state == S_WR) && (st.op == OP_BUFFER);

  we_pulse_a: assert property ($fell(F_WE_N) |-> !F_WE_N ##1 !F_WE_N) // [RULE_01]
    else $error("write strobe shorter than two cycles");
  rst_pulse_a: assert property ($fell(F_RESET_N) |-> !F_RESET_N[*5]) // [RULE_05]
    else $error("reset pulse too short");
  buf_count_a: assert property (wr_buf && st.idx == 6'd3 |-> F_DQ_O == 8'(st.cnt - 6'd1)) // [RULE_08]
    else $error("wrong location count written");
  page_hold_a: assert property (wr_buf && st.idx >= 6'd4 && st.idx < st.cnt + 6'd4
                                |-> F_A[22:5] == st.addr[22:5]) // [RULE_10]
    else $error("load outside buffer page");
  confirm_cmd_a: assert property (wr_buf && st.idx == st.cnt + 6'd4
                                  |-> F_DQ_O == CMD_BUF_CONF && F_A == st.addr) // [RULE_12]
    else $error("confirm not written at sector address");
  abort_seq_a: assert property ((st.state == S_WR) && st.op == OP_ABORT_RST && st.idx == 6'd2
                                |-> F_DQ_O == CMD_RESET) // [RULE_14]
    else $error("abort reset sequence wrong");
  erase_setup_a: assert property ((st.state == S_WR) && (st.op inside {OP_CHIP, OP_SECTOR})
                                  && st.idx == 6'd2 |-> F_DQ_O == CMD_ERASE) // [RULE_19]
    else $error("erase setup code wrong");
  poll_abort_a: assert property (EN && st.state == S_RD && st.timer == 8'd0 && st.polling
                                 && st.poll_buf && q[1] && q[7] != st.poll_d[7]
                                 |=> st.aborted && st.state == S_IDLE) // [RULE_13]
    else $error("buffer abort not reported");

  byte_done_c: cover property (st.op == OP_BYTE && $rose(st.done));
  buf_abort_c: cover property ($rose(st.aborted));
  suspend_c:   cover property ($rose(st.suspended));
  id_read_c:   cover property (st.op == OP_ID && $rose(st.done));

endmodule

// *** verification/fpes_flash_model.sv ***
`timescale 1ns/1ps
module fpes_flash_model
  import fpes_pkg::*;
#(
  parameter int         BUSY_T = 200,
  parameter int         BUF_SZ = 32,
  parameter logic [7:0] MFR    = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV    = 8'hA7  // arbitrary value
) (
  input  wire logic [22:0] a,
  input  wire logic [7:0]  dq,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        ce_n,
  input  wire logic        reset_n,
  output logic      [7:0]  q,
  output logic             ready_busy_n
);
  logic [7:0]  mem [int];
  logic [7:0]  bm [int];
  logic [7:0]  rv, tgt;
  logic [22:0] ta, pg;
  logic        busy, susp, idm, abt, tmo, tog, prog;
  int          seq, left, t, st;
  initial begin
    {busy, susp, idm, abt, tmo, tog, prog, rv, tgt} = '0;
    {seq, t, st} = '0;
  end
  assign ready_busy_n = !busy;
  // released bus shows the inverse, never a stale byte
  assign q = (!oe_n && !ce_n) ? rv : ~rv;
  function automatic logic [7:0] rdm(input logic [22:0] x);
    return mem.exists(x) ? mem[x] : ERASED;
  endfunction
  task automatic go(input logic [22:0] x, input logic [7:0] d, input logic p);
    ta = x;
    tgt = d;
    prog = p;
    busy = 1'b1;
    t = BUSY_T;
    if (p) tmo = |(d & ~rdm(x)); // a 0 never becomes 1
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge we_n) if (!ce_n && reset_n) begin
    if (busy) begin
      if (prog && dq == CMD_SUSPEND) st = 50; // other writes ignored
    end else case (seq)
      0: if (dq == CMD_UNLOCK1) seq = 1;
         else if (susp && dq == CMD_RESUME) {susp, busy} = 2'b01;
         else if (dq == CMD_RESET) idm = 1'b0;
      1: seq = (dq == CMD_UNLOCK2) ? 2 : 0;
      2: begin
        seq = 0;
        if (dq == CMD_RESET) {abt, idm} = '0;
        else if (abt) seq = 0;
        else if (dq == CMD_PROG) seq = 3;
        else if (dq == CMD_BUF_LOAD) begin pg = a; seq = 4; end
        else if (dq == CMD_ERASE) seq = 5;
        else if (dq == CMD_ID) idm = 1'b1;
      end
      3: begin seq = 0; mem[a] = rdm(a) & dq; go(a, dq, 1'b1); end
      4: begin
        bm.delete();
        left = int'(dq) + 1;
        tgt = dq;
        seq = 6;
        if (left > BUF_SZ) begin abt = 1'b1; seq = 0; end
        // a full load plus five command writes stays within 37 cycles
      end
      6, 7: begin
        tgt = dq;
        ta = a;
        if (a[22:12] != pg[22:12] || (seq == 7 && a[22:5] != pg[22:5])) begin
          abt = 1'b1;
          seq = 0;
        end else begin
          pg = a;
          bm[a] = dq; // repeats count, last data wins
          left--;
          seq = (left > 0) ? 7 : 8;
        end
      end
      8: begin
        seq = 0;
        if (dq != CMD_BUF_CONF || a[22:12] != pg[22:12]) abt = 1'b1;
        else begin
          foreach (bm[k]) mem[k] = rdm(23'(k)) & bm[k];
          go(ta, tgt, 1'b1);
        end
      end
      5: seq = (dq == CMD_UNLOCK1) ? 9 : 0;
      9: seq = (dq == CMD_UNLOCK2) ? 10 : 0;
      10: begin
        seq = 0;
        if (dq == CMD_CHIP) mem.delete();
        if (dq == CMD_SECTOR) foreach (mem[k]) if (k[22:12] == a[22:12]) mem[k] = ERASED;
        if (dq == CMD_CHIP || dq == CMD_SECTOR) go(a, ERASED, 1'b0);
      end
      default: seq = 0;
    endcase
  end
  // internal timer; the device itself has no clock pin
  always #100 begin
    if (!reset_n) begin {busy, susp, abt, idm, tmo} = '0; {seq, st} = '0; end
    if (st == 1) {busy, susp} = 2'b01;
    if (st > 0) st--;
    if (busy && !tmo && !susp && st == 0 && t > 0) begin
      t--;
      if (t == 0) busy = 1'b0;
    end
  end
  always @(negedge oe_n) if (!ce_n) begin
    tog = !tog;
    if (busy || abt) rv = {~tgt[7], tog, tmo, 2'b00, !prog & tog, abt, 1'b0};
    else if (idm) rv = (a[1:0] == 2'b00) ? MFR : (a[1:0] == 2'b01) ? DEV : 8'h00;
    else rv = rdm(a);
  end
endmodule

// *** verification/flash_program_erase_sequencer_bench.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module flash_program_erase_sequencer_bench;
  import fpes_pkg::*;
  logic        CLK, RST_N, EN, WR, RD, F_DQ_OE_N, F_WE_N, F_OE_N, F_CE_N, F_RESET_N;
  logic        ryby_n, nb;
  logic [7:0]  ADDR, F_DQ_O, mq, f_dq;
  logic [31:0] WDATA, RDATA, v;
  logic [22:0] F_A;
  int          failures, checked, cyc;
  assign f_dq = F_DQ_OE_N ? mq : F_DQ_O;
  fpes_host #(.BUF_DEPTH(32)) dut_u (.CLK(CLK), .RST_N(RST_N), .EN(EN), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .F_A(F_A), .F_DQ_I(f_dq),
    .F_DQ_O(F_DQ_O), .F_DQ_OE_N(F_DQ_OE_N), .F_WE_N(F_WE_N), .F_OE_N(F_OE_N),
    .F_CE_N(F_CE_N), .F_RESET_N(F_RESET_N), .F_READY_BUSY_N(ryby_n));
  // smaller far-side buffer, so a full host load trips the count abort
  fpes_flash_model #(.BUF_SZ(16)) mdl_u (.a(F_A), .dq(f_dq), .we_n(F_WE_N), .oe_n(F_OE_N),
    .ce_n(F_CE_N),
    .reset_n(F_RESET_N), .q(mq), .ready_busy_n(ryby_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    WR <= 1'b1; ADDR <= a; WDATA <= d;
    @(posedge CLK); WR <= 1'b0; #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    RD <= 1'b1; ADDR <= a;
    @(posedge CLK); RD <= 1'b0; #1; d = RDATA;
  endtask
  task automatic op(input logic [3:0] c);
    int n = 0;
    wr(REG_CTRL, {28'h0, c});
    nb = 1'b0;
    rd(REG_CTRL, v);
    while (v[ST_BUSY] !== 1'b0 && n < 9000) begin
      rd(REG_CTRL, v); n++; nb |= (v[ST_RYBY] === 1'b0);
    end
    `CHK("op end", 1'b0, v[ST_BUSY])
  endtask
  task automatic t_byte();
    EN <= 1'b0; wr(REG_DATA, 32'h0000_00A5); EN <= 1'b1;
    rd(REG_DATA, v); `CHK("frozen", 8'h00, v[7:0])
    wr(REG_ADDR, 32'h0000_1234); wr(REG_DATA, 32'h0000_005A); op(4'h1);
    `CHK("done", 1'b1, v[ST_DONE])
    `CHK("busy seen", 1'b1, nb)
    `CHK("byte", 8'h5A, mdl_u.rdm(23'h1234))
    rd(REG_POLL, v); `CHK("poll", 8'h5A, v[7:0])
    wr(REG_DATA, 32'h0000_00FF); op(4'h1);
    `CHK("error", 1'b1, v[ST_ERROR])
    op(4'h9);
    `CHK("ready", 1'b1, ryby_n)
    `CHK("kept 0", 8'h5A, mdl_u.rdm(23'h1234))
  endtask
  task automatic t_buffer();
    wr(REG_ADDR, 32'h0000_2040);
    wr(REG_LOAD, 32'h0000_0311); wr(REG_LOAD, 32'h0000_0322); wr(REG_LOAD, 32'h0000_0733);
    rd(REG_LOAD, v); `CHK("count", 6'd3, v[5:0])
    op(4'h2);
    `CHK("buf ok", 2'b01, {v[ST_ABORT], v[ST_DONE]})
    `CHK("last wins", 8'h22, mdl_u.rdm(23'h2043))
    `CHK("page", 8'h33, mdl_u.rdm(23'h2047))
    wr(REG_ADDR, 32'h0000_3000);
    for (int i = 0; i < 33; i++) wr(REG_LOAD, {19'h0, 5'(i), 8'h00});
    rd(REG_LOAD, v); `CHK("capped", 6'd32, v[5:0])
    op(4'h2);
    `CHK("abort", 1'b1, v[ST_ABORT])
    op(4'h8);
    `CHK("abort reset", 1'b0, mdl_u.abt)
  endtask
  task automatic t_erase();
    wr(REG_ADDR, 32'h0000_2000); op(4'h4);
    `CHK("sector", 8'hFF, mdl_u.rdm(23'h2047))
    `CHK("other sector", 8'h5A, mdl_u.rdm(23'h1234))
    op(4'h3);
    `CHK("chip", 8'hFF, mdl_u.rdm(23'h1234))
  endtask
  task automatic t_suspend();
    int n = 0;
    wr(REG_ADDR, 32'h0000_4000); wr(REG_DATA, 32'h0000_003C); wr(REG_CTRL, 32'h0000_0001);
    while ((mdl_u.busy !== 1'b1 || F_OE_N !== 1'b0) && n < 300) begin @(posedge CLK); n++; end
    #1; op(4'h5);
    `CHK("suspended", 1'b1, v[ST_SUSP])
    `CHK("still 3C", 8'h3C, mdl_u.tgt)
    op(4'h7); rd(REG_ID, v);
    `CHK("id", {mdl_u.DEV, mdl_u.MFR}, v[15:0])
    `CHK("back to suspend", 1'b1, mdl_u.susp)
    op(4'h6);
    `CHK("resumed", 1'b1, v[ST_DONE])
    `CHK("prog", 8'h3C, mdl_u.rdm(23'h4000))
    rd(8'hFC, v); `CHK("unmapped", 32'h0000_0000, v)
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 60000) begin failures++; give_verdict(); end
  end
  initial begin
    {RST_N, WR, RD, nb} = '0; EN = 1'b1; ADDR = '0; WDATA = '0;
    {failures, checked, cyc} = '0;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK); #1;
    t_byte();
    t_buffer();
    t_erase();
    t_suspend();
    give_verdict();
  end
endmodule
